// ---- design/ccd_pkg.sv ----
package ccd_pkg;
  // register indices as printed; byte address is four times the index
  localparam logic [7:0]  IDX_CTRL     = 8'h28;
  localparam logic [7:0]  IDX_BOUND    = 8'h29;
  localparam logic [7:0]  IDX_SEGCFG   = 8'h2a;
  localparam logic [7:0]  IDX_SEGA     = 8'h2b;
  localparam logic [7:0]  IDX_SEGB     = 8'h2c;
  localparam logic [7:0]  IDX_STATUS   = 8'h30;
  localparam logic [7:0]  IDX_PROBE    = 8'h31;
  localparam int          NUM_REGS     = 8;
  localparam logic [7:0]  CTRL_RESET   = 8'h08;
  localparam logic [7:0]  BOUND_RESET  = 8'ha0;
  localparam logic [7:0]  SEGCFG_RESET = 8'h00;
  localparam logic [7:0]  SEGBASE_RESET = 8'h00;
  localparam logic [3:0]  BOUND_RSVD   = 4'ha;
  localparam int          CTRL_EN_BIT  = 7;
  localparam int          CTRL_PERF_BIT = 6;
  localparam int          CTRL_ALLNC_BIT = 5;
  localparam int          CTRL_LOWNC_BIT = 4;
  localparam int          CTRL_TIM_LSB = 2;
  localparam int          CTRL_SIZE_LSB = 0;
  localparam int          SEGA_EN_BIT  = 7;
  localparam int          SEGA_SZ_LSB  = 4;
  localparam int          SEGB_EN_BIT  = 3;
  localparam int          SEGB_SZ_LSB  = 0;
  localparam logic [1:0]  TIM_INVALID  = 2'h0;
  localparam logic [1:0]  TIM_ZWS      = 2'h1;
  localparam logic [1:0]  TIM_ONEWS    = 2'h2;
  localparam logic [1:0]  TIM_ZWS_EXT  = 2'h3;
  localparam logic [23:0] LOW_NC_START = 24'h0a0000;
  localparam logic [23:0] LOW_NC_END   = 24'h100000;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_RESP = 2'b01
  } ccd_bus_e;
endpackage

// ---- design/ccd_regfile.sv ----
`timescale 1ns/1ns
module ccd_regfile (
  input  wire logic       sys_clk,   // system clock
  input  wire logic       rstSyncB,  // synchronised reset, low active
  input  wire logic       wrEn,      // write strobe
  input  wire logic [2:0] wrIdx,     // write slot
  input  wire logic [7:0] wrData,    // write value
  input  wire logic [2:0] rdIdx,     // read slot
  output logic      [7:0] rdData,    // registered read value
  output logic      [7:0] ctrl,      // slot 0
  output logic      [7:0] bound,     // slot 1
  output logic      [7:0] segCfg,    // slot 2
  output logic      [7:0] segA,      // slot 3
  output logic      [7:0] segB       // slot 4
);
  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] bound;
    logic [7:0] segCfg;
    logic [7:0] segA;
    logic [7:0] segB;
    logic [7:0] rd;
  } ccd_rf_s;
  ccd_rf_s st_q, st_d;

  always_comb begin
    st_d = st_q;
    if (wrEn) begin
      case (wrIdx)
        3'h0: st_d.ctrl = wrData;
        3'h1: st_d.bound = {ccd_pkg::BOUND_RSVD, wrData[3:0]};
        3'h2: st_d.segCfg = wrData;
        3'h3: st_d.segA = wrData;
        3'h4: st_d.segB = wrData;
        default: st_d.rd = st_q.rd;
      endcase
    end
    case (rdIdx)
      3'h0: st_d.rd = st_q.ctrl;
      3'h1: st_d.rd = st_q.bound;
      3'h2: st_d.rd = st_q.segCfg;
      3'h3: st_d.rd = st_q.segA;
      3'h4: st_d.rd = st_q.segB;
      default: st_d.rd = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstSyncB) begin
    if (!rstSyncB) begin
      st_q.ctrl <= ccd_pkg::CTRL_RESET;
      st_q.bound <= ccd_pkg::BOUND_RESET;
      st_q.segCfg <= ccd_pkg::SEGCFG_RESET;
      st_q.segA <= ccd_pkg::SEGBASE_RESET;
      st_q.segB <= ccd_pkg::SEGBASE_RESET;
      st_q.rd <= 8'h00;
    end else begin
      st_q <= st_d;
    end
  end

  assign rdData = st_q.rd;
  assign ctrl = st_q.ctrl;
  assign bound = st_q.bound;
  assign segCfg = st_q.segCfg;
  assign segA = st_q.segA;
  assign segB = st_q.segB;
endmodule

// ---- design/ccd_cache_decode.sv ----
// Summary of operation
// - Cache works only with control bit 7 set
// - Bit 5 makes every access non-cacheable
// - Bit 4 makes 640KB-1MB non-cacheable
// - Two-bit field selects cache write-hit timing
// - Two-bit field sets cache size, span
// - Upper bound vs A[23:20]; zero disables
// - Two segments, own enables, reset disabled
// - Segment size code 64KB through 8MB
// - Segment A start A[23:16], reset zero
// - Segment B start A[23:16], reset zero
//
// Register access over AXI4-Lite was decided locally.
`timescale 1ns/1ns
module ccd_cache_decode (
  input  wire logic        sys_clk,        // 125 MHz system clock
  input  wire logic        rst_b,          // async reset, low active
  input  wire logic [31:0] s_axi_awaddr,   // write address
  input  wire logic        s_axi_awvalid,  // write address valid
  output logic             s_axi_awready,  // write address ready
  input  wire logic [31:0] s_axi_wdata,    // write data
  input  wire logic [3:0]  s_axi_wstrb,    // write byte enables
  input  wire logic        s_axi_wvalid,   // write data valid
  output logic             s_axi_wready,   // write data ready
  output logic [1:0]       s_axi_bresp,    // write response
  output logic             s_axi_bvalid,   // write response valid
  input  wire logic        s_axi_bready,   // write response ready
  input  wire logic [31:0] s_axi_araddr,   // read address
  input  wire logic        s_axi_arvalid,  // read address valid
  output logic             s_axi_arready,  // read address ready
  output logic [31:0]      s_axi_rdata,    // read data
  output logic [1:0]       s_axi_rresp,    // read response
  output logic             s_axi_rvalid,   // read data valid
  input  wire logic        s_axi_rready,   // read data ready
  input  wire logic [23:0] accAddr,        // local memory access address
  input  wire logic        accValid,       // access address valid
  output logic             accCacheable,   // registered cacheability verdict
  output logic             cacheEnable,    // write-back cache running
  output logic             dramPerfMode,   // dram optimisation bit
  output logic [1:0]       writeHitTiming, // write-hit timing code
  output logic             writeHitWait,   // one wait state on write hit
  output logic             cacheWriteExt,  // extend cache_write_strobe_n
  output logic             timingInvalid,  // invalid timing code programmed
  output logic [1:0]       cacheSizeSel,   // cache size code
  output logic [3:0]       cacheSpanMb     // cacheable span, A[23:20] units, 0 = 16MB
);
  typedef struct packed {
    logic [1:0]  rstSync;
    ccd_pkg::ccd_bus_e wrSt;
    ccd_pkg::ccd_bus_e rdSt;
    logic        awHave;
    logic        wHave;
    logic [31:0] awAddr;
    logic [31:0] wData;
    logic [3:0]  wStrb;
    logic [1:0]  bResp;
    logic [1:0]  rResp;
    logic        rPend;
    logic [2:0]  rdSlot;
    logic [31:0] rData;
    logic        awRdy;
    logic        wRdy;
    logic        bValid;
    logic        arRdy;
    logic        rValid;
    logic        acc;
  } ccd_top_s;
  ccd_top_s st_q, st_d;

  logic       rstSyncB;
  logic [7:0] ctrl, bound, segCfg, segA, segB, rfRd;
  logic       rfWr;
  logic [2:0] rfWrIdx, rfRdIdx;
  logic       wrOk;
  logic       rdOk;
  logic       arTake;
  logic [2:0] arSlot;
  logic [7:0] statusWord;

  // printed index to local slot; 7 means unmapped
  function automatic logic [2:0] slotOf(input logic [31:0] addr);
    logic [2:0] s;
    s = 3'h7;
    if (addr[1:0] == 2'h0 && addr[31:10] == 22'h0) begin
      case (addr[9:2])
        ccd_pkg::IDX_CTRL:   s = 3'h0;
        ccd_pkg::IDX_BOUND:  s = 3'h1;
        ccd_pkg::IDX_SEGCFG: s = 3'h2;
        ccd_pkg::IDX_SEGA:   s = 3'h3;
        ccd_pkg::IDX_SEGB:   s = 3'h4;
        ccd_pkg::IDX_STATUS: s = 3'h5;
        ccd_pkg::IDX_PROBE:  s = 3'h6;
        default:             s = 3'h7;
      endcase
    end
    return s;
  endfunction

  // segment hit: compare address bits above the segment size
  function automatic logic segHit(input logic [23:0] a, input logic [7:0] base,
                                  input logic [2:0] sz);
    logic [7:0] mask;
    mask = 8'hff << sz;
    return ((a[23:16] ^ base) & mask) == 8'h00;
  endfunction

  assign rstSyncB = st_q.rstSync[1];

  ccd_regfile u_rf (
    .sys_clk  (sys_clk),
    .rstSyncB (rstSyncB),
    .wrEn     (rfWr),
    .wrIdx    (rfWrIdx),
    .wrData   (st_q.wData[7:0]),
    .rdIdx    (rfRdIdx),
    .rdData   (rfRd),
    .ctrl     (ctrl),
    .bound    (bound),
    .segCfg   (segCfg),
    .segA     (segA),
    .segB     (segB)
  );

  logic inLow, belowBound, hitA, hitB, verdict;
  always_comb begin
    inLow = accAddr >= ccd_pkg::LOW_NC_START && accAddr < ccd_pkg::LOW_NC_END;
    belowBound = bound[3:0] == 4'h0 || accAddr[23:20] < bound[3:0];
    hitA = segCfg[ccd_pkg::SEGA_EN_BIT] &&
           segHit(accAddr, segA, segCfg[ccd_pkg::SEGA_SZ_LSB +: 3]);
    hitB = segCfg[ccd_pkg::SEGB_EN_BIT] &&
           segHit(accAddr, segB, segCfg[ccd_pkg::SEGB_SZ_LSB +: 3]);
    verdict = ctrl[ccd_pkg::CTRL_EN_BIT]
              && !ctrl[ccd_pkg::CTRL_ALLNC_BIT]
              && !(ctrl[ccd_pkg::CTRL_LOWNC_BIT] && inLow)
              && belowBound && !hitA && !hitB;
  end

  always_comb begin
    rfWrIdx = slotOf(st_q.awAddr);
    wrOk = rfWrIdx < 3'h5;
    // byte lane 0 carries the 8-bit register
    rfWr = st_q.wrSt == ccd_pkg::BUS_IDLE && st_q.awHave && st_q.wHave &&
           wrOk && st_q.wStrb[0];
    arSlot = slotOf(s_axi_araddr);
    arTake = s_axi_arvalid && st_q.arRdy;
    rdOk = arSlot != 3'h7;
    // keep the taken slot: the master may move araddr after the handshake
    rfRdIdx = arTake ? arSlot : st_q.rdSlot;
  end

  always_comb begin
    st_d = st_q;
    st_d.rstSync = {st_q.rstSync[0], 1'b1};
    if (s_axi_awvalid && st_q.awRdy) begin
      st_d.awHave = 1'b1;
      st_d.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st_q.wRdy) begin
      st_d.wHave = 1'b1;
      st_d.wData = s_axi_wdata;
      st_d.wStrb = s_axi_wstrb;
    end
    case (st_q.wrSt)
      ccd_pkg::BUS_IDLE: begin
        if (st_q.awHave && st_q.wHave) begin
          st_d.bResp = wrOk ? ccd_pkg::RESP_OKAY : ccd_pkg::RESP_SLVERR;
          st_d.wrSt = ccd_pkg::BUS_RESP;
        end
      end
      ccd_pkg::BUS_RESP: begin
        if (s_axi_bready) begin
          st_d.wrSt = ccd_pkg::BUS_IDLE;
          st_d.awHave = 1'b0;
          st_d.wHave = 1'b0;
        end
      end
      default: st_d.wrSt = ccd_pkg::BUS_IDLE;
    endcase
    case (st_q.rdSt)
      ccd_pkg::BUS_IDLE: begin
        if (arTake) begin
          st_d.rdSt = ccd_pkg::BUS_RESP;
          st_d.rPend = 1'b1;
          st_d.rdSlot = arSlot;
          st_d.rResp = rdOk ? ccd_pkg::RESP_OKAY : ccd_pkg::RESP_SLVERR;
        end
      end
      ccd_pkg::BUS_RESP: begin
        st_d.rPend = 1'b0;
        if (s_axi_rready && !st_q.rPend) begin
          st_d.rdSt = ccd_pkg::BUS_IDLE;
        end
      end
      default: st_d.rdSt = ccd_pkg::BUS_IDLE;
    endcase
    // read word captured while rPend, so rdata is a flop when rvalid rises
    if (st_q.rPend) begin
      case (st_q.rdSlot)
        3'h5: st_d.rData = {24'h0, statusWord};
        3'h6: st_d.rData = {31'h0, accCacheable};
        3'h7: st_d.rData = 32'h0;
        default: st_d.rData = {24'h0, rfRd};
      endcase
    end
    if (accValid) begin
      st_d.acc = verdict;
    end
    // handshake outputs registered from the next state
    st_d.awRdy = !st_d.awHave;
    st_d.wRdy = !st_d.wHave;
    st_d.bValid = st_d.wrSt == ccd_pkg::BUS_RESP;
    st_d.arRdy = st_d.rdSt == ccd_pkg::BUS_IDLE;
    st_d.rValid = st_d.rdSt == ccd_pkg::BUS_RESP && !st_d.rPend;
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // status slot: decoded state; probe slot: last verdict
  assign statusWord = {cacheEnable, timingInvalid, writeHitWait, cacheWriteExt,
                       cacheSpanMb};

  logic [5:0]  outQ;
  logic [3:0]  spanQ;
  logic [1:0]  timQ, sizeQ;
  always_ff @(posedge sys_clk or negedge rstSyncB) begin
    if (!rstSyncB) begin
      // reset timing code is one wait state, so the wait flag starts set
      outQ <= 6'h08;
      spanQ <= 4'h2;
      timQ <= ccd_pkg::TIM_ONEWS;
      sizeQ <= 2'h0;
    end else begin
      outQ[0] <= st_q.acc;
      outQ[1] <= ctrl[ccd_pkg::CTRL_EN_BIT];
      outQ[2] <= ctrl[ccd_pkg::CTRL_PERF_BIT];
      timQ <= ctrl[ccd_pkg::CTRL_TIM_LSB +: 2];
      outQ[3] <= ctrl[ccd_pkg::CTRL_TIM_LSB +: 2] == ccd_pkg::TIM_ONEWS;
      outQ[4] <= ctrl[ccd_pkg::CTRL_TIM_LSB +: 2] == ccd_pkg::TIM_ZWS_EXT;
      outQ[5] <= ctrl[ccd_pkg::CTRL_TIM_LSB +: 2] == ccd_pkg::TIM_INVALID;
      sizeQ <= ctrl[ccd_pkg::CTRL_SIZE_LSB +: 2];
      spanQ <= 4'(5'h2 << ctrl[ccd_pkg::CTRL_SIZE_LSB +: 2]);
    end
  end

  assign s_axi_awready = st_q.awRdy;
  assign s_axi_wready  = st_q.wRdy;
  assign s_axi_bvalid  = st_q.bValid;
  assign s_axi_bresp   = st_q.bResp;
  assign s_axi_arready = st_q.arRdy;
  assign s_axi_rvalid  = st_q.rValid;
  assign s_axi_rresp   = st_q.rResp;
  assign s_axi_rdata   = st_q.rData;
  assign accCacheable  = outQ[0];
  assign cacheEnable   = outQ[1];
  assign dramPerfMode  = outQ[2];
  assign writeHitWait  = outQ[3];
  assign cacheWriteExt = outQ[4];
  assign timingInvalid = outQ[5];
  assign writeHitTiming = timQ;
  assign cacheSizeSel  = sizeQ;
  assign cacheSpanMb   = spanQ;

  AST_ALLNC_BLOCKS: assert property (@(posedge sys_clk) disable iff (!rstSyncB)
    (accValid && ctrl[ccd_pkg::CTRL_ALLNC_BIT]) |=> ##1 !accCacheable)
    else $error("cacheable despite global override");
  AST_DISABLED: assert property (@(posedge sys_clk) disable iff (!rstSyncB)
    (accValid && !ctrl[ccd_pkg::CTRL_EN_BIT]) |=> ##1 !accCacheable)
    else $error("cacheable with cache disabled");
  AST_LOWNC: assert property (@(posedge sys_clk) disable iff (!rstSyncB)
    (accValid && ctrl[ccd_pkg::CTRL_LOWNC_BIT] && accAddr[23:16] == 8'h0a) |=> ##1 !accCacheable)
    else $error("low area cached");
  AST_LOWNC_TOP: assert property (@(posedge sys_clk) disable iff (!rstSyncB)
    (accValid && ctrl[ccd_pkg::CTRL_LOWNC_BIT] && accAddr == 24'h0fffff) |=> ##1 !accCacheable)
    else $error("top of low area cached");
  AST_BOUND: assert property (@(posedge sys_clk) disable iff (!rstSyncB)
    (accValid && bound[3:0] != 4'h0 && accAddr[23:20] >= bound[3:0]) |=> ##1 !accCacheable)
    else $error("cacheable above bound");
  AST_SEGA: assert property (@(posedge sys_clk) disable iff (!rstSyncB)
    (accValid && segCfg[ccd_pkg::SEGA_EN_BIT] && accAddr[23:16] == segA) |=> ##1 !accCacheable)
    else $error("cacheable inside segment A");
  AST_SEGB: assert property (@(posedge sys_clk) disable iff (!rstSyncB)
    (accValid && segCfg[ccd_pkg::SEGB_EN_BIT] && accAddr[23:16] == segB) |=> ##1 !accCacheable)
    else $error("cacheable inside segment B");
  AST_TIMING: assert property (@(posedge sys_clk) disable iff (!rstSyncB)
    ##1 (writeHitWait == ($past(ctrl[3:2]) == 2'h2)))
    else $error("write-hit wait wrong");
  AST_EXT: assert property (@(posedge sys_clk) disable iff (!rstSyncB)
    ##1 (cacheWriteExt == ($past(ctrl[3:2]) == 2'h3)))
    else $error("extended write strobe wrong");
  AST_SPAN: assert property (@(posedge sys_clk) disable iff (!rstSyncB)
    ##1 ($past(ctrl[1:0]) == 2'h3 |-> cacheSpanMb == 4'h0))
    else $error("span wrong for largest cache");
  AST_FULLPASS: assert property (@(posedge sys_clk) disable iff (!rstSyncB)
    (accValid && ctrl == 8'h88 && bound[3:0] == 4'h0 && segCfg == 8'h00)
      |=> ##1 accCacheable)
    else $error("plain access not cacheable");
endmodule

// ---- tb/test_cacheability_config_decode.sv ----
`timescale 1ns/1ns
`define CHK(nm, ex, gt) begin n_compared++; if ((gt) !== (ex)) begin mismatches++; \
  $display("MISMATCH %s expected %h seen %h", nm, ex, gt); end end
module test_cacheability_config_decode;
  logic        sys_clk, rst_b, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_rready, accValid, chkAcc;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [3:0]  s_axi_wstrb, cacheSpanMb;
  logic [23:0] accAddr;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, writeHitTiming, cacheSizeSel;
  logic        accCacheable, cacheEnable, dramPerfMode, writeHitWait, cacheWriteExt;
  logic        timingInvalid;
  int          mismatches = 0;
  int          n_compared = 0;
  int          cycles = 0;
  int          seed = 9841;
  logic [33:0] expQ[$];
  logic [7:0]  cfg[5];

  ccd_cache_decode DUT (
    .sys_clk(sys_clk), .rst_b(rst_b),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .accAddr(accAddr),
    .accValid(accValid), .accCacheable(accCacheable), .cacheEnable(cacheEnable),
    .dramPerfMode(dramPerfMode), .writeHitTiming(writeHitTiming), .writeHitWait(writeHitWait),
    .cacheWriteExt(cacheWriteExt), .timingInvalid(timingInvalid),
    .cacheSizeSel(cacheSizeSel), .cacheSpanMb(cacheSpanMb)
  );

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      test_done();
    end
  end

  // results are judged in arrival order against the oldest note
  always @(posedge sys_clk) begin
    logic [33:0] e;
    if (s_axi_bvalid && s_axi_bready) begin
      e = expQ.pop_front();
      `CHK("bresp", e, {s_axi_bresp, 32'h0})
    end
    if (s_axi_rvalid && s_axi_rready) begin
      e = expQ.pop_front();
      `CHK("rresp_rdata", e, {s_axi_rresp, s_axi_rdata})
    end
    if (chkAcc) begin
      e = expQ.pop_front();
      `CHK("accCacheable", e, {33'h0, accCacheable})
    end
  end

  task automatic wr(input logic [31:0] a, input logic [7:0] d, input logic [3:0] s,
                    input logic [1:0] r);
    bit aw;
    bit w;
    aw = 0;
    w = 0;
    expQ.push_back({r, 32'h0});
    @(posedge sys_clk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= {24'h0, d};
    s_axi_wstrb   <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    while (!(aw && w)) begin
      @(posedge sys_clk);
      if (!aw && s_axi_awready) begin
        aw = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w && s_axi_wready) begin
        w = 1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge sys_clk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [31:0] a, input logic [33:0] ex);
    expQ.push_back(ex);
    @(posedge sys_clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do @(posedge sys_clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge sys_clk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
  endtask

  // write one register slot, mirror it, read it back
  task automatic setr(input int i, input logic [7:0] d);
    wr(32'(32'ha0 + 4 * i), d, 4'hf, ccd_pkg::RESP_OKAY);
    cfg[i] = (i == 1) ? {ccd_pkg::BOUND_RSVD, d[3:0]} : d;
    rd(32'(32'ha0 + 4 * i), {ccd_pkg::RESP_OKAY, 24'h0, cfg[i]});
  endtask

  task automatic dec;
    logic [7:0] c;
    logic [3:0] sp;
    c  = cfg[0];
    sp = (c[1:0] == 2'h3) ? 4'h0 : 4'(4'h2 << c[1:0]);
    repeat (3) @(posedge sys_clk);
    `CHK("decoded", {c[7], c[6], c[3:2], c[3:2] == 2'h2, c[3:2] == 2'h3, c[3:2] == 2'h0,
      c[1:0], sp}, {cacheEnable, dramPerfMode, writeHitTiming, writeHitWait, cacheWriteExt,
      timingInvalid, cacheSizeSel, cacheSpanMb})
    rd(32'hc0, {2'h0, 24'h0, c[7], c[3:2] == 2'h0, c[3:2] == 2'h2, c[3:2] == 2'h3, sp});
  endtask

  function automatic logic model(input logic [23:0] ad);
    logic [2:0] sa;
    logic [2:0] sb;
    sa = cfg[2][6:4];
    sb = cfg[2][2:0];
    if (!cfg[0][7] || cfg[0][5]) return 1'b0;
    if (cfg[0][4] && ad >= ccd_pkg::LOW_NC_START && ad < ccd_pkg::LOW_NC_END) return 1'b0;
    if (cfg[1][3:0] != 4'h0 && ad[23:20] >= cfg[1][3:0]) return 1'b0;
    if (cfg[2][7] && (ad[23:16] >> sa) == (cfg[3] >> sa)) return 1'b0;
    if (cfg[2][3] && (ad[23:16] >> sb) == (cfg[4] >> sb)) return 1'b0;
    return 1'b1;
  endfunction

  task automatic acc(input logic [23:0] ad);
    @(posedge sys_clk);
    accAddr  <= ad;
    accValid <= 1'b1;
    @(posedge sys_clk);
    accValid <= 1'b0;
    repeat (3) @(posedge sys_clk);
    expQ.push_back({33'h0, model(ad)});
    chkAcc <= 1'b1;
    @(posedge sys_clk);
    chkAcc <= 1'b0;
    rd(32'hc4, {2'h0, 31'h0, model(ad)});
  endtask

  initial begin
    logic [31:0] r;
    logic [7:0]  c;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 4'h0;
    {s_axi_rready, accValid, chkAcc, rst_b} = 4'h0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
    s_axi_wstrb = 4'hf;
    accAddr     = 24'h0;
    repeat (10) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge sys_clk);
    cfg = '{ccd_pkg::CTRL_RESET, ccd_pkg::BOUND_RESET, 8'h00, 8'h00, 8'h00};
    for (int i = 0; i < 5; i++) rd(32'(32'ha0 + 4 * i), {2'h0, 24'h0, cfg[i]});
    dec();
    acc(24'h012345);
    // every timing and size code, cache on and off
    for (int i = 0; i < 32; i++) begin
      setr(0, {i[4], ~i[4], 2'h0, i[3:0]});
      dec();
      acc(24'h012345);
    end
    rd(32'h40, {ccd_pkg::RESP_SLVERR, 32'h0});
    rd(32'ha1, {ccd_pkg::RESP_SLVERR, 32'h0});
    wr(32'h40, 8'hff, 4'hf, ccd_pkg::RESP_SLVERR);
    wr(32'ha8, 8'hff, 4'he, ccd_pkg::RESP_OKAY);
    rd(32'ha8, {2'h0, 24'h0, cfg[2]});
    repeat (40) begin
      r = $random(seed);
      // size fixed at 16MB span so the span never masks the verdict
      c = {~(r[9] & r[8]), 1'b0, r[10] & r[11], r[4], 1'b1, r[3], 2'h3};
      setr(0, c);
      setr(1, r[15:12]);
      setr(2, r[23:16]);
      setr(3, r[31:24] & (8'hff << cfg[2][6:4]));
      r = $random(seed);
      setr(4, r[7:0] & (8'hff << cfg[2][2:0]));
      acc({cfg[3], 16'h0});
      acc(24'({cfg[4], 16'h0} - 24'h1));
      acc({cfg[1][3:0], 20'h0});
      acc(24'({cfg[1][3:0], 20'h0} - 24'h1));
      acc(r[31:8]);
      acc(24'h0a0000 + {14'h0, r[9:0]});
      acc(24'h0fffff);
      acc({cfg[4], 16'hffff});
    end
    test_done();
  end
endmodule
